// file: hw/fuse_readback_defs.svh
// Purpose: Offsets, field positions and timing counts for the fuse/lock/signature readback
// Assumes: 125 MHz sys_clk, 16-bit address pointer, 8-bit control register
// Notes: Shared by the core end and the device end
`ifndef FUSE_READBACK_DEFS_SVH
`define FUSE_READBACK_DEFS_SVH

// ************************************************
// Control register field positions
// ************************************************
`define CTL_SPM_EN_BIT 0
`define CTL_PAGE_ERASE_BIT 1
`define CTL_PAGE_WRITE_BIT 2
`define CTL_LOCK_FUSE_SEL_BIT 3
`define CTL_RWW_REENABLE_BIT 4
`define CTL_SIG_SEL_BIT 5
`define CTL_RWW_BUSY_BIT 6
`define CTL_RESET_VALUE 8'h00

// ************************************************
// Pointer addresses
// ************************************************
`define ADDR_LOW_FUSE 16'h0000
`define ADDR_LOCK 16'h0001
`define ADDR_EXT_FUSE 16'h0002
`define ADDR_HIGH_FUSE 16'h0003
`define ADDR_SIG_1 16'h0000
`define ADDR_OSC_CAL 16'h0001
`define ADDR_SIG_2 16'h0002
`define ADDR_SIG_3 16'h0004

// ************************************************
// Timing
// ************************************************
`define LOAD_WINDOW 3'h3
`define STORE_WINDOW 3'h4
`define CLK_FREQ_MHZ 125
`define NV_WR_MIN_US 3700
`define NV_WR_MAX_US 4500
// Cycle counts are plain products of us and MHz, no rounding; exact at 125 MHz
`define NV_WR_MIN_CYC ((`NV_WR_MIN_US * `CLK_FREQ_MHZ))
`define NV_WR_MAX_CYC ((`NV_WR_MAX_US * `CLK_FREQ_MHZ))
`define UNDEF_FILL 1'b1

`endif

// file: hw/fuse_readback_pkg.sv
// Purpose: Types shared by both ends of the readback link
// Assumes: Nothing beyond the defs header
// Notes: Constants live in fuse_readback_defs.svh
package fuse_readback_pkg;
   typedef enum logic [1:0] {ARM_NONE, ARM_LOCK_FUSE, ARM_SIGNATURE, ARM_PROGRAM} arm_mode_t;
   typedef enum logic [1:0] {OP_NONE, OP_PAGE_ERASE, OP_PAGE_WRITE, OP_LOCK_WRITE} nv_op_t;
   typedef enum logic [1:0] {HS_IDLE, HS_WAIT} host_state_t;
endpackage : fuse_readback_pkg

// file: hw/fuse_readback_if.sv
// Purpose: Core-to-device link for control writes, loads and stores
// Assumes: Single clock, both ends on sys_clk
// Notes: Requests are one-cycle pulses from the core
interface fuse_readback_if (
   input wire logic sys_clk,
   input wire logic rst_n
);
   logic ctrl_we;
   logic [7:0] ctrl_wdata;
   logic [7:0] ctrl_rdata;
   logic [15:0] z_ptr;
   logic [7:0] store_data;
   logic load_req;
   logic store_req;
   logic load_ack;
   logic [7:0] load_data;

   modport core (
      input sys_clk, rst_n, ctrl_rdata, load_ack, load_data,
      output ctrl_we, ctrl_wdata, z_ptr, store_data, load_req, store_req
   );
   modport dev (
      input sys_clk, rst_n, ctrl_we, ctrl_wdata, z_ptr, store_data, load_req, store_req,
      output ctrl_rdata, load_ack, load_data
   );
endinterface : fuse_readback_if

// file: hw/fuse_readback_dev.sv
// Purpose: Device end: arms and serves lock, fuse and signature loads, times flash writes
// Assumes: Nonvolatile values arrive as static inputs; flash array answers combinationally
// Notes: The write timer sits on por_n so a system reset cannot cut a write short
`include "fuse_readback_defs.svh"

module fuse_readback_dev
   import fuse_readback_pkg::*;
#(
   parameter int NV_WR_CYCLES = `NV_WR_MIN_CYC,
   parameter logic [7:0] SIG_BYTE_1 = 8'h5A, // Arbitrary value
   parameter logic [7:0] SIG_BYTE_2 = 8'h3C, // Arbitrary value
   parameter logic [7:0] SIG_BYTE_3 = 8'h81  // Arbitrary value
) (
   fuse_readback_if.dev bus,
   input wire logic por_n,
   input wire logic [5:0] lock_bits,
   input wire logic [7:0] low_fuse_byte,
   input wire logic [7:0] high_fuse_byte,
   input wire logic [3:0] extended_fuse_byte,
   input wire logic [7:0] osc_cal,
   output logic [15:0] flash_addr,
   input wire logic [7:0] flash_rdata,
   output nv_op_t nv_op,
   output logic nv_busy,
   output logic [15:0] nv_addr,
   output logic [7:0] nv_data
);

   // ************************************************
   // Load result selection
   // ************************************************

   // Lock/fuse bits pass as stored: 0 programmed, 1 unprogrammed
   function automatic logic [7:0] fuse_sel(input logic [15:0] a);
      case (a)
         `ADDR_LOW_FUSE: fuse_sel = low_fuse_byte;
         `ADDR_LOCK: fuse_sel = {{2{`UNDEF_FILL}}, lock_bits};
         `ADDR_EXT_FUSE: fuse_sel = {{4{`UNDEF_FILL}}, extended_fuse_byte};
         `ADDR_HIGH_FUSE: fuse_sel = high_fuse_byte;
         default: fuse_sel = 8'hFF;
      endcase
   endfunction : fuse_sel

   // Reserved signature addresses return all ones
   function automatic logic [7:0] sig_sel(input logic [15:0] a);
      case (a)
         `ADDR_SIG_1: sig_sel = SIG_BYTE_1;
         `ADDR_OSC_CAL: sig_sel = osc_cal;
         `ADDR_SIG_2: sig_sel = SIG_BYTE_2;
         `ADDR_SIG_3: sig_sel = SIG_BYTE_3;
         default: sig_sel = 8'hFF;
      endcase
   endfunction : sig_sel

   // ************************************************
   // Arming and control register
   // ************************************************
   arm_mode_t arm_q, arm_d;
   logic [2:0] cnt_q, cnt_d;
   logic [1:0] page_cmd_q, page_cmd_d;
   logic rww_busy_q, rww_busy_d;
   logic [7:0] ctrl_rdata_q, ctrl_rdata_d;
   logic rd_pend_q, rd_pend_d;
   logic rd_ack_q, rd_ack_d;
   arm_mode_t rd_src_q, rd_src_d;
   logic [15:0] rd_addr_q, rd_addr_d;
   logic [7:0] rd_data_q, rd_data_d;
   logic nv_start;
   nv_op_t nv_start_op;
   logic load_take;

   assign load_take = bus.load_req && !rd_pend_q;

   // Arming decode, window count and auto-clear
   always_comb begin
      arm_d = arm_q;
      cnt_d = cnt_q;
      page_cmd_d = page_cmd_q;
      rww_busy_d = rww_busy_q;
      nv_start = 1'b0;
      nv_start_op = OP_NONE;
      if (bus.ctrl_we && !nv_busy) begin
         cnt_d = 3'h1;
         page_cmd_d = {bus.ctrl_wdata[`CTL_PAGE_WRITE_BIT], bus.ctrl_wdata[`CTL_PAGE_ERASE_BIT]};
         if (!bus.ctrl_wdata[`CTL_SPM_EN_BIT]) begin
            arm_d = ARM_NONE;
            cnt_d = 3'h0;
         end else if (bus.ctrl_wdata[`CTL_SIG_SEL_BIT]) begin
            arm_d = ARM_SIGNATURE;
         end else if (bus.ctrl_wdata[`CTL_LOCK_FUSE_SEL_BIT]) begin
            arm_d = ARM_LOCK_FUSE;
         end else if (bus.ctrl_wdata[`CTL_RWW_REENABLE_BIT]) begin
            // Re-enable only clears the busy flag, nothing is armed
            rww_busy_d = 1'b0;
            arm_d = ARM_NONE;
            cnt_d = 3'h0;
         end else begin
            arm_d = ARM_PROGRAM;
         end
      end else if (arm_q != ARM_NONE) begin
         cnt_d = cnt_q + 3'h1;
         if (load_take && cnt_q <= `LOAD_WINDOW &&
             (arm_q == ARM_LOCK_FUSE || arm_q == ARM_SIGNATURE)) begin
            arm_d = ARM_NONE;
            cnt_d = 3'h0;
         end else if (bus.store_req && cnt_q <= `STORE_WINDOW && arm_q != ARM_SIGNATURE) begin
            nv_start = 1'b1;
            if (arm_q == ARM_LOCK_FUSE) begin
               nv_start_op = OP_LOCK_WRITE;
            end else if (page_cmd_q[1]) begin
               nv_start_op = OP_PAGE_WRITE;
               rww_busy_d = 1'b1;
            end else if (page_cmd_q[0]) begin
               nv_start_op = OP_PAGE_ERASE;
               rww_busy_d = 1'b1;
            end else begin
               nv_start = 1'b0; // Buffer load: outside this block
            end
            arm_d = ARM_NONE;
            cnt_d = 3'h0;
         end else if (arm_q == ARM_SIGNATURE && cnt_q >= `LOAD_WINDOW) begin
            arm_d = ARM_NONE;
            cnt_d = 3'h0;
         end else if (cnt_q >= `STORE_WINDOW) begin
            // Lock/fuse arming also serves a lock write, so it lives the store window
            arm_d = ARM_NONE;
            cnt_d = 3'h0;
         end
      end
   end

   // Load pipeline: take, address flash, return
   always_comb begin
      rd_pend_d = rd_pend_q;
      rd_src_d = rd_src_q;
      rd_addr_d = rd_addr_q;
      rd_data_d = rd_data_q;
      rd_ack_d = 1'b0;
      if (load_take) begin
         rd_pend_d = 1'b1;
         rd_addr_d = bus.z_ptr;
         rd_src_d = (cnt_q <= `LOAD_WINDOW && (arm_q == ARM_LOCK_FUSE || arm_q == ARM_SIGNATURE)) ?
                    arm_q : ARM_NONE;
      end else if (rd_pend_q) begin
         rd_pend_d = 1'b0;
         rd_ack_d = 1'b1;
         case (rd_src_q)
            ARM_LOCK_FUSE: rd_data_d = fuse_sel(rd_addr_q);
            ARM_SIGNATURE: rd_data_d = sig_sel(rd_addr_q);
            default: rd_data_d = flash_rdata;
         endcase
      end
   end

   // Status view: enable bit stays up while a write runs
   always_comb begin
      ctrl_rdata_d = `CTL_RESET_VALUE;
      ctrl_rdata_d[`CTL_SPM_EN_BIT] = (arm_q != ARM_NONE) || nv_busy;
      ctrl_rdata_d[`CTL_LOCK_FUSE_SEL_BIT] = (arm_q == ARM_LOCK_FUSE);
      ctrl_rdata_d[`CTL_SIG_SEL_BIT] = (arm_q == ARM_SIGNATURE);
      ctrl_rdata_d[`CTL_PAGE_ERASE_BIT] = (arm_q == ARM_PROGRAM) && page_cmd_q[0];
      ctrl_rdata_d[`CTL_PAGE_WRITE_BIT] = (arm_q == ARM_PROGRAM) && page_cmd_q[1];
      ctrl_rdata_d[`CTL_RWW_BUSY_BIT] = rww_busy_q;
   end

   // System-reset state
   always_ff @(posedge bus.sys_clk or negedge bus.rst_n) begin
      if (!bus.rst_n) begin
         arm_q <= ARM_NONE;
         cnt_q <= 3'h0;
         page_cmd_q <= 2'h0;
         rww_busy_q <= 1'b0;
         ctrl_rdata_q <= `CTL_RESET_VALUE;
         rd_pend_q <= 1'b0;
         rd_ack_q <= 1'b0;
         rd_src_q <= ARM_NONE;
         rd_addr_q <= 16'h0000;
         rd_data_q <= 8'h00;
      end else begin
         arm_q <= arm_d;
         cnt_q <= cnt_d;
         page_cmd_q <= page_cmd_d;
         rww_busy_q <= rww_busy_d;
         ctrl_rdata_q <= ctrl_rdata_d;
         rd_pend_q <= rd_pend_d;
         rd_ack_q <= rd_ack_d;
         rd_src_q <= rd_src_d;
         rd_addr_q <= rd_addr_d;
         rd_data_q <= rd_data_d;
      end
   end

   assign bus.ctrl_rdata = ctrl_rdata_q;
   assign bus.load_ack = rd_ack_q;
   assign bus.load_data = rd_data_q;
   assign flash_addr = rd_addr_q;

   // ************************************************
   // Write timer
   // ************************************************
   logic [19:0] nv_cnt_q, nv_cnt_d;
   nv_op_t nv_op_q, nv_op_d;
   logic [15:0] nv_addr_q, nv_addr_d;
   logic [7:0] nv_data_q, nv_data_d;

   // Fixed count from the calibrated clock, inside 3.7..4.5 ms
   always_comb begin
      nv_cnt_d = nv_cnt_q;
      nv_op_d = nv_op_q;
      nv_addr_d = nv_addr_q;
      nv_data_d = nv_data_q;
      if (nv_op_q != OP_NONE) begin
         if (nv_cnt_q == 20'h00001) begin
            nv_op_d = OP_NONE;
            nv_cnt_d = 20'h00000;
         end else begin
            nv_cnt_d = nv_cnt_q - 20'h00001;
         end
      end else if (nv_start) begin
         nv_op_d = nv_start_op;
         nv_cnt_d = NV_WR_CYCLES[19:0];
         nv_addr_d = bus.z_ptr;
         nv_data_d = bus.store_data;
      end
   end

   // Only power-on clears this; system reset lets the write finish
   always_ff @(posedge bus.sys_clk or negedge por_n) begin
      if (!por_n) begin
         nv_cnt_q <= 20'h00000;
         nv_op_q <= OP_NONE;
         nv_addr_q <= 16'h0000;
         nv_data_q <= 8'h00;
      end else begin
         nv_cnt_q <= nv_cnt_d;
         nv_op_q <= nv_op_d;
         nv_addr_q <= nv_addr_d;
         nv_data_q <= nv_data_d;
      end
   end

   assign nv_op = nv_op_q;
   assign nv_busy = (nv_op_q != OP_NONE);
   assign nv_addr = nv_addr_q;
   assign nv_data = nv_data_q;

endmodule : fuse_readback_dev

// file: hw/fuse_readback_host.sv
// Purpose: Core end: issues control writes, loads and stores over the link
// Assumes: User side pulses one request at a time
// Notes: Loads to reserved signature addresses are refused locally
`include "fuse_readback_defs.svh"

module fuse_readback_host
   import fuse_readback_pkg::*;
(
   fuse_readback_if.core bus,
   input wire logic usr_ctrl_we,
   input wire logic [7:0] usr_ctrl_wdata,
   input wire logic [15:0] usr_z,
   input wire logic [7:0] usr_store_data,
   input wire logic usr_load,
   input wire logic usr_store,
   output logic usr_busy,
   output logic usr_done,
   output logic usr_refused,
   output logic [7:0] usr_rdata,
   output logic [7:0] usr_status
);

   // ************************************************
   // Request drive and answer capture
   // ************************************************
   host_state_t st_q, st_d;
   logic [2:0] sig_cnt_q, sig_cnt_d;
   logic we_q, load_q, store_q, done_q, refused_q;
   logic we_d, load_d, store_d, done_d, refused_d;
   logic [7:0] wdata_q, wdata_d, sdata_q, sdata_d, rdata_q, rdata_d;
   logic [15:0] z_q, z_d;
   logic sig_ok;

   assign sig_ok = (usr_z == `ADDR_SIG_1) || (usr_z == `ADDR_OSC_CAL) ||
                   (usr_z == `ADDR_SIG_2) || (usr_z == `ADDR_SIG_3);

   // One request per cycle; loads wait for the answer
   always_comb begin
      st_d = st_q;
      // Count 1..3 only, matching the loads that the device end still serves as armed
      sig_cnt_d = (sig_cnt_q != 3'h0 && sig_cnt_q < `LOAD_WINDOW) ? sig_cnt_q + 3'h1 : 3'h0;
      we_d = 1'b0;
      load_d = 1'b0;
      store_d = 1'b0;
      done_d = 1'b0;
      refused_d = 1'b0;
      wdata_d = wdata_q;
      sdata_d = sdata_q;
      z_d = usr_z;
      rdata_d = rdata_q;
      case (st_q)
         HS_IDLE: begin
            if (usr_ctrl_we) begin
               we_d = 1'b1;
               wdata_d = usr_ctrl_wdata;
               sig_cnt_d = (usr_ctrl_wdata[`CTL_SIG_SEL_BIT] && usr_ctrl_wdata[`CTL_SPM_EN_BIT]) ? 3'h1 : 3'h0;
            end else if (usr_load) begin
               if (sig_cnt_q != 3'h0 && !sig_ok) begin
                  refused_d = 1'b1;
               end else begin
                  load_d = 1'b1;
                  st_d = HS_WAIT;
                  sig_cnt_d = 3'h0;
               end
            end else if (usr_store) begin
               store_d = 1'b1;
               sdata_d = usr_store_data;
            end
         end
         HS_WAIT: begin
            z_d = z_q;
            if (bus.load_ack) begin
               rdata_d = bus.load_data;
               done_d = 1'b1;
               st_d = HS_IDLE;
            end
         end
         default: st_d = HS_IDLE;
      endcase
   end

   always_ff @(posedge bus.sys_clk or negedge bus.rst_n) begin
      if (!bus.rst_n) begin
         st_q <= HS_IDLE;
         sig_cnt_q <= 3'h0;
         we_q <= 1'b0;
         load_q <= 1'b0;
         store_q <= 1'b0;
         done_q <= 1'b0;
         refused_q <= 1'b0;
         wdata_q <= 8'h00;
         sdata_q <= 8'h00;
         z_q <= 16'h0000;
         rdata_q <= 8'h00;
      end else begin
         st_q <= st_d;
         sig_cnt_q <= sig_cnt_d;
         we_q <= we_d;
         load_q <= load_d;
         store_q <= store_d;
         done_q <= done_d;
         refused_q <= refused_d;
         wdata_q <= wdata_d;
         sdata_q <= sdata_d;
         z_q <= z_d;
         rdata_q <= rdata_d;
      end
   end

   assign bus.ctrl_we = we_q;
   assign bus.ctrl_wdata = wdata_q;
   assign bus.z_ptr = z_q;
   assign bus.store_data = sdata_q;
   assign bus.load_req = load_q;
   assign bus.store_req = store_q;
   assign usr_busy = (st_q == HS_WAIT);
   assign usr_done = done_q;
   assign usr_refused = refused_q;
   assign usr_rdata = rdata_q;
   assign usr_status = bus.ctrl_rdata;

endmodule : fuse_readback_host

// file: bench/fuse_readback_monitor.sv
// Purpose: Concurrent checks on the core-to-device readback link
// Assumes: One sys_clk domain, rst_n async active low
// Notes: Sees link signals only; write timing is judged in tb
module fuse_readback_monitor (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic ctrl_we,
   input wire logic [7:0] ctrl_wdata,
   input wire logic [7:0] ctrl_rdata,
   input wire logic [15:0] z_ptr,
   input wire logic load_req,
   input wire logic store_req,
   input wire logic load_ack,
   input wire logic [7:0] load_data
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************
   // Link checks
   // ****************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   // Loads are answered once, two cycles on
   a_load_answer_delay: assert property (load_req |-> ##2 load_ack)
      else $error("load not answered two cycles later");
   a_ack_has_cause: assert property (load_ack |-> $past(load_req, 2))
      else $error("answer without a load");
   a_ack_single_pulse: assert property (load_ack |=> !load_ack)
      else $error("answer longer than one cycle");
   a_data_holds: assert property (!load_ack |-> $stable(load_data))
      else $error("load data moved without answer");
   // Undefined upper bits must read high
   a_lock_upper_ones: assert property ((ctrl_we && ctrl_wdata == 8'h09 ##1 load_req && z_ptr == 16'h0001)
      |-> ##2 load_data[7:6] == 2'b11)
      else $error("lock byte upper bits not high");
   a_ext_upper_ones: assert property ((ctrl_we && ctrl_wdata == 8'h09 ##1 load_req && z_ptr == 16'h0002)
      |-> ##2 load_data[7:4] == 4'hF)
      else $error("extended byte upper bits not high");
   // Unused arming must die, margin covers status lag
   a_arm_timeout_clears: assert property ((ctrl_we && (ctrl_wdata[3] || ctrl_wdata[5])
      ##1 !(load_req || store_req || ctrl_we) [*3]) |-> ##3 !ctrl_rdata[3] && !ctrl_rdata[5])
      else $error("arming outlived its window");
   a_read_clears_arm: assert property (load_ack |=> !ctrl_rdata[3] && !ctrl_rdata[5])
      else $error("arming left after read");

   c_lock_read: cover property (ctrl_we && ctrl_wdata == 8'h09 ##1 load_req);
   c_sig_read: cover property (ctrl_we && ctrl_wdata == 8'h21 ##1 load_req);
   c_store: cover property (ctrl_we ##1 store_req);
endmodule : fuse_readback_monitor

// file: bench/tb.sv
// Purpose: Self-checking bench driving the core end against the device end
// Assumes: Write time shortened to NV_WR cycles
// Notes: Flash answers addr xor 5C so ordinary reads are predictable
module tb
   import fuse_readback_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int NV_WR = 20;
   localparam logic [7:0] SIG_1 = 8'h1E; // Arbitrary value
   localparam logic [7:0] SIG_2 = 8'h94; // Arbitrary value
   localparam logic [7:0] SIG_3 = 8'h0B; // Arbitrary value
   localparam logic [7:0] OSC = 8'h97;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic por_n = 1'b0;
   logic usr_ctrl_we = 1'b0, usr_load = 1'b0, usr_store = 1'b0;
   logic [7:0] usr_ctrl_wdata = 8'h00, usr_store_data = 8'h00;
   logic [15:0] usr_z = 16'h0000;
   logic usr_busy, usr_done, usr_refused, nv_busy;
   logic [7:0] usr_rdata, usr_status, flash_rdata, nv_data;
   logic [15:0] flash_addr, nv_addr;
   nv_op_t nv_op;
   int mismatches = 0, compares = 0, i, busy_len;
   logic [7:0] lf_exp [4] = '{8'h62, 8'hED, 8'hF5, 8'hD9};
   logic [7:0] sig_exp [4] = '{SIG_1, OSC, SIG_2, SIG_3};
   logic [15:0] sig_adr [4] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004};

   // ****************
   // Structure
   // ****************
   always #4 sys_clk = ~sys_clk;
   // Flash stand-in, a pattern so stale data cannot match
   assign flash_rdata = flash_addr[7:0] ^ 8'h5C;

   fuse_readback_if fuse_readback_if_inst (.sys_clk(sys_clk), .rst_n(rst_n));
   fuse_readback_host fuse_readback_host_inst (.bus(fuse_readback_if_inst), .usr_ctrl_we(usr_ctrl_we),
      .usr_ctrl_wdata(usr_ctrl_wdata), .usr_z(usr_z), .usr_store_data(usr_store_data), .usr_load(usr_load),
      .usr_store(usr_store), .usr_busy(usr_busy), .usr_done(usr_done), .usr_refused(usr_refused),
      .usr_rdata(usr_rdata), .usr_status(usr_status));
   fuse_readback_dev #(.NV_WR_CYCLES(NV_WR), .SIG_BYTE_1(SIG_1), .SIG_BYTE_2(SIG_2), .SIG_BYTE_3(SIG_3))
      fuse_readback_dev_inst (.bus(fuse_readback_if_inst), .por_n(por_n), .lock_bits(6'h2D),
      .low_fuse_byte(8'h62), .high_fuse_byte(8'hD9), .extended_fuse_byte(4'h5), .osc_cal(OSC),
      .flash_addr(flash_addr), .flash_rdata(flash_rdata), .nv_op(nv_op), .nv_busy(nv_busy),
      .nv_addr(nv_addr), .nv_data(nv_data));
   fuse_readback_monitor fuse_readback_monitor_inst (.sys_clk(sys_clk), .rst_n(rst_n),
      .ctrl_we(fuse_readback_if_inst.ctrl_we), .ctrl_wdata(fuse_readback_if_inst.ctrl_wdata),
      .ctrl_rdata(fuse_readback_if_inst.ctrl_rdata), .z_ptr(fuse_readback_if_inst.z_ptr),
      .load_req(fuse_readback_if_inst.load_req), .store_req(fuse_readback_if_inst.store_req),
      .load_ack(fuse_readback_if_inst.load_ack), .load_data(fuse_readback_if_inst.load_data));

   // ****************
   // Tasks
   // ****************
   task automatic end_of_test();
      if (mismatches == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Inputs always move 1 ns after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick

   task automatic ctl(input logic [7:0] w);
      usr_ctrl_wdata = w;
      usr_ctrl_we = 1'b1;
      tick(1);
      usr_ctrl_we = 1'b0;
   endtask : ctl

   // Bounded wait on done, then arming must be gone
   task automatic load(input logic [15:0] z, input logic [7:0] exp);
      usr_z = z;
      usr_load = 1'b1;
      tick(1);
      usr_load = 1'b0;
      for (int k = 0; k < 8 && usr_done !== 1'b1; k++) tick(1);
      check("load data", usr_rdata, exp);
      tick(1);
      check("status", usr_status, 8'h00);
   endtask : load

   // Store one cycle after arming; reset may land mid-write
   task automatic store(input logic [7:0] w, input nv_op_t op, input bit rst_mid);
      ctl(w);
      usr_store_data = 8'hC3;
      usr_store = 1'b1;
      tick(1);
      usr_store = 1'b0;
      for (int k = 0; k < 6 && nv_busy !== 1'b1; k++) tick(1);
      check("write kind", nv_op, op);
      busy_len = 0;
      while (nv_busy === 1'b1 && busy_len < 100) begin
         busy_len++;
         if (rst_mid && busy_len == 5) rst_n = 1'b0;
         if (busy_len == 7) rst_n = 1'b1;
         tick(1);
      end
      check("write length", busy_len[15:0], NV_WR);
      tick(2);
   endtask : store

   // ****************
   // Sequence
   // ****************
   initial begin
      tick(2);
      rst_n = 1'b1;
      por_n = 1'b1;
      load(16'h0042, 8'h42 ^ 8'h5C);
      for (i = 0; i < 4; i++) begin
         ctl(8'h09);
         load(i[15:0], lf_exp[i]);
      end
      ctl(8'h09);
      tick(2);
      load(16'h0001, 8'hED);
      ctl(8'h09);
      tick(3);
      load(16'h0001, 8'h01 ^ 8'h5C);
      for (i = 0; i < 4; i++) begin
         ctl(8'h21);
         load(sig_adr[i], sig_exp[i]);
      end
      ctl(8'h21);
      tick(3);
      load(16'h0000, 8'h5C);
      // Reserved signature place is stopped at the core end
      ctl(8'h21);
      usr_z = 16'h0003;
      usr_load = 1'b1;
      tick(1);
      usr_load = 1'b0;
      check("refused", usr_refused, 1'b1);
      check("no load sent", usr_busy, 1'b0);
      tick(1);
      tick(6);
      store(8'h09, OP_LOCK_WRITE, 1'b1);
      check("write data", nv_data, 8'hC3);
      check("write addr", nv_addr, 16'h0003);
      store(8'h03, OP_PAGE_ERASE, 1'b0);
      store(8'h05, OP_PAGE_WRITE, 1'b0);
      // Busy flag of the rewritten section holds until re-enabled
      check("rww busy", usr_status, 8'h40);
      ctl(8'h11);
      tick(2);
      check("rww clear", usr_status, 8'h00);
      end_of_test();
   end

   // Whole sequence needs well under 1000 cycles
   initial begin
      repeat (5000) @(posedge sys_clk);
      mismatches++;
      end_of_test();
   end
endmodule : tb
